/* core/core_exec_unit.v */
// Instruction execution unit with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"

// Functional notes
// - Literal add into accumulator, arithmetic flags
// - File add to destination, arithmetic flags
// - Destination bit picks accumulator or file for file add, AND and invert
// - File AND, only zero flag
// - Literal AND into accumulator, zero flag
// - File invert to destination, zero flag
// - Clear chosen file bit, flags kept
// - Set chosen file bit, flags kept
// - Jump loads immediate and latch page bits
// - Jump takes two cycles, flags kept
module core_exec_unit #(
   parameter ICYC_CLKS = `ICYC_CLKS_DEF,
   parameter FILE_DEPTH = `FILE_DEPTH_DEF
) (
   input wire clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg busy
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;
   localparam [3:0] CNT_ONE = 4'h1;
   localparam [3:0] ICYC = ICYC_CLKS[3:0];

   // ==========================================================
   // State
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [3:0] cnt_reg;
   reg [3:0] cnt_next;
   reg [13:0] insn_reg;
   reg [13:0] insn_next;
   reg [7:0] acc_reg;
   reg [7:0] acc_next;
   reg carry_reg;
   reg carry_next;
   reg nibble_reg;
   reg nibble_next;
   reg zero_reg;
   reg zero_next;
   reg [12:0] pc_reg;
   reg [12:0] pc_next;
   reg [4:0] latch_reg;
   reg [4:0] latch_next;
   reg [6:0] faddr_reg;
   reg [6:0] faddr_next;
   reg [31:0] rdMux;
   reg rdErr;
   reg settle_reg;

   wire [2:0] op;
   wire destFile;
   wire isJump;
   wire [3:0] lastCnt;
   wire running;
   wire execNow;
   wire lastNow;
   wire apbDone;
   wire apbWr;
   wire [7:0] aluRes;
   wire aluC;
   wire aluDc;
   wire aluZ;
   wire updArith;
   wire updZero;
   wire fileOp;
   wire [7:0] fileQ;
   wire memWe;
   wire [6:0] memAddr;
   wire [7:0] memWdata;
   wire toFile;

   assign op = insn_reg[`OPC_HI:`OPC_LO];
   assign destFile = insn_reg[`DEST_BIT];
   assign isJump = (op == `OP_JUMP);
   assign running = state_reg[1];
   assign lastCnt = isJump ? ((ICYC << 1) - CNT_ONE) : (ICYC - CNT_ONE);
   // results commit at count one; non-jump ops end after ICYC clocks
   assign execNow = running && (cnt_reg == CNT_ONE);
   assign lastNow = running && (cnt_reg == lastCnt);
   assign apbDone = psel && penable && pready;
   assign apbWr = apbDone && pwrite;

   // ==========================================================
   // Datapath
   exec_alu alu (
      .op(op),
      .acc(acc_reg),
      .fileVal(fileQ),
      .lit(insn_reg[7:0]),
      .bitSel(insn_reg[`BSEL_HI:`BSEL_LO]),
      .result(aluRes),
      .carry(aluC),
      .nibble(aluDc),
      .zero(aluZ),
      .updArith(updArith),
      .updZero(updZero),
      .fileOp(fileOp)
   );

   assign toFile = fileOp &&
      (destFile || op == `OP_CLR_BIT || op == `OP_SET_BIT);

   // Bus and core never write in the same cycle: bus stalls while busy
   assign memWe = (execNow && toFile) ||
      (apbWr && paddr == `OFS_FDATA);
   assign memAddr = running ? insn_reg[`FADR_HI:0] : faddr_reg;
   assign memWdata = running ? aluRes : pwdata[7:0];

   file_ram #(
      .DEPTH(FILE_DEPTH),
      .AW(7),
      .DW(8)
   ) ram (
      .clk(clk),
      .we(memWe),
      .addr(memAddr),
      .wdata(memWdata),
      .rdata(fileQ)
   );

   // ==========================================================
   // Read mux and decode
   always @* begin
      rdMux = 32'h00000000;
      rdErr = 1'b0;
      case (paddr)
         `OFS_INSN: rdMux = {18'h00000, insn_reg};
         `OFS_ACC: rdMux = {24'h000000, acc_reg};
         `OFS_FLAGS: rdMux = {29'h00000000, zero_reg, nibble_reg,
            carry_reg};
         `OFS_LATCH: rdMux = {27'h0000000, latch_reg};
         `OFS_PC: rdMux = {19'h00000, pc_reg};
         `OFS_FADDR: rdMux = {25'h0000000, faddr_reg};
         `OFS_FDATA: rdMux = {24'h000000, fileQ};
         `OFS_STAT: rdMux = {31'h00000000, running};
         default: rdErr = 1'b1;
      endcase
   end

   // ==========================================================
   // Next state
   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      insn_next = insn_reg;
      acc_next = acc_reg;
      carry_next = carry_reg;
      nibble_next = nibble_reg;
      zero_next = zero_reg;
      pc_next = pc_reg;
      latch_next = latch_reg;
      faddr_next = faddr_reg;
      case (state_reg)
         ST_IDLE: begin
            cnt_next = 4'h0;
            if (apbWr) begin
               case (paddr)
                  `OFS_INSN: begin
                     insn_next = pwdata[13:0];
                     state_next = ST_RUN;
                  end
                  `OFS_ACC: acc_next = pwdata[7:0];
                  `OFS_FLAGS: begin
                     carry_next = pwdata[`FLG_CARRY];
                     nibble_next = pwdata[`FLG_NIBBLE];
                     zero_next = pwdata[`FLG_ZERO];
                  end
                  `OFS_LATCH: latch_next = pwdata[4:0];
                  `OFS_FADDR: faddr_next = pwdata[6:0];
                  default: faddr_next = faddr_reg;
               endcase
            end
         end
         ST_RUN: begin
            cnt_next = cnt_reg + CNT_ONE;
            if (execNow) begin
               // destination zero keeps result in accumulator
               if (fileOp ? !toFile : !isJump) begin
                  acc_next = aluRes;
               end
               if (updArith) begin
                  carry_next = aluC;
                  nibble_next = aluDc;
               end
               if (updZero) begin
                  zero_next = aluZ;
               end
            end
            if (lastNow) begin
               state_next = ST_IDLE;
               cnt_next = 4'h0;
               // page bits from latch, low bits immediate
               if (isJump) begin
                  pc_next = {latch_reg[`LATCH_PG_HI:`LATCH_PG_LO],
                     insn_reg[`JMP_HI:0]};
               end else begin
                  pc_next = pc_reg + 13'h0001;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
            cnt_next = 4'h0;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 4'h0;
         insn_reg <= 14'h0000;
         acc_reg <= `ACC_RST;
         carry_reg <= 1'b0;
         nibble_reg <= 1'b0;
         zero_reg <= 1'b0;
         pc_reg <= `PC_RST;
         latch_reg <= `LATCH_RST;
         faddr_reg <= 7'h00;
         busy <= 1'b0;
         settle_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         insn_reg <= insn_next;
         acc_reg <= acc_next;
         carry_reg <= carry_next;
         nibble_reg <= nibble_next;
         zero_reg <= zero_next;
         pc_reg <= pc_next;
         latch_reg <= latch_next;
         faddr_reg <= faddr_next;
         busy <= state_next[1];
         settle_reg <= lastNow;
      end
   end

   // ==========================================================
   // APB answer
   // Stalling while busy keeps bus writes off the core's results
   always @(posedge clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      // Gap cycle lets the file read port return to faddr
      end else if (psel && penable && !pready && !running &&
         !settle_reg) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : rdMux;
         pslverr <= rdErr;
      end else begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

endmodule

`default_nettype wire

/* core/exec_alu.v */
// Result and flag computation for the instruction subset
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"

module exec_alu (
   input wire [2:0] op,
   input wire [7:0] acc,
   input wire [7:0] fileVal,
   input wire [7:0] lit,
   input wire [2:0] bitSel,
   output reg [7:0] result,
   output reg carry,
   output reg nibble,
   output reg zero,
   output reg updArith,
   output reg updZero,
   output reg fileOp
);

   // Sum with carry out of bit 7 and bit 3
   function [9:0] addFlags;
      input [7:0] a;
      input [7:0] b;
      reg [8:0] full;
      reg [4:0] low;
      begin
         full = {1'b0, a} + {1'b0, b};
         low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
         addFlags = {full[8], low[4], full[7:0]};
      end
   endfunction

   function [7:0] bitMask;
      input [2:0] b;
      begin
         bitMask = 8'h01 << b;
      end
   endfunction

   reg [9:0] sum;

   // ==========================================================
   // Operation decode
   always @* begin
      sum = 10'h000;
      result = 8'h00;
      updArith = 1'b0;
      updZero = 1'b0;
      fileOp = 1'b0;
      case (op)
         `OP_ADD_LIT: begin
            sum = addFlags(acc, lit);
            result = sum[7:0];
            updArith = 1'b1;
            updZero = 1'b1;
         end
         `OP_AND_LIT: begin
            result = acc & lit;
            updZero = 1'b1;
         end
         `OP_ADD_FILE: begin
            sum = addFlags(acc, fileVal);
            result = sum[7:0];
            updArith = 1'b1;
            updZero = 1'b1;
            fileOp = 1'b1;
         end
         `OP_AND_FILE: begin
            result = acc & fileVal;
            updZero = 1'b1;
            fileOp = 1'b1;
         end
         `OP_INV_FILE: begin
            result = ~fileVal;
            updZero = 1'b1;
            fileOp = 1'b1;
         end
         `OP_CLR_BIT: begin
            result = fileVal & ~bitMask(bitSel);
            fileOp = 1'b1;
         end
         `OP_SET_BIT: begin
            result = fileVal | bitMask(bitSel);
            fileOp = 1'b1;
         end
         default: begin
            result = 8'h00;
         end
      endcase
      carry = sum[9];
      nibble = sum[8];
      zero = ~|result;
   end

endmodule

`default_nettype wire

/* core/exec_defs.vh */
// Constants for the instruction execution unit
`ifndef EXEC_DEFS_VH
`define EXEC_DEFS_VH

// ==========================================================
// APB register byte offsets
`define OFS_INSN 8'h00
`define OFS_ACC 8'h04
`define OFS_FLAGS 8'h08
`define OFS_LATCH 8'h0C
`define OFS_PC 8'h10
`define OFS_FADDR 8'h14
`define OFS_FDATA 8'h18
`define OFS_STAT 8'h1C

// ==========================================================
// Flag register fields
`define FLG_CARRY 0
`define FLG_NIBBLE 1
`define FLG_ZERO 2

// ==========================================================
// Instruction word layout (14 bits)
`define INSN_W 14
`define OPC_HI 13
`define OPC_LO 11
`define DEST_BIT 7
`define BSEL_HI 9
`define BSEL_LO 7
`define FADR_HI 6
`define JMP_HI 10
`define LATCH_PG_HI 4
`define LATCH_PG_LO 3

// ==========================================================
// Operation codes (top three bits of the word)
`define OP_ADD_LIT 3'h0
`define OP_AND_LIT 3'h1
`define OP_ADD_FILE 3'h2
`define OP_AND_FILE 3'h3
`define OP_INV_FILE 3'h4
`define OP_CLR_BIT 3'h5
`define OP_SET_BIT 3'h6
`define OP_JUMP 3'h7

// ==========================================================
// Reset values and timing
`define ACC_RST 8'h00
`define FLAGS_RST 3'h0
`define LATCH_RST 5'h00
`define PC_RST 13'h0000
`define ICYC_CLKS_DEF 4
`define FILE_DEPTH_DEF 128

`endif

/* core/file_ram.v */
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module file_ram #(
   parameter DEPTH = 128,
   parameter AW = 7,
   parameter DW = 8
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   output reg [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:DEPTH-1];

   // ==========================================================
   // Write first, read back new data next cycle
   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= we ? wdata : mem[addr];
   end

endmodule

`default_nettype wire

/* tb/core_instruction_execute_subset_test.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"
module core_instruction_execute_subset_test;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00, acc;
   logic [7:0] mem [0:127];
   logic [31:0] pwdata = 32'h0, rd;
   wire [31:0] prdata;
   wire pready, pslverr, busy;
   logic [3:0] romAddr = 4'h0;
   logic [13:0] romWord;
   logic [2:0] flg;
   logic [4:0] latch;
   logic [12:0] pc;
   int nErrors = 0, samplesChecked = 0;
   always #5 clk = ~clk;
   core_exec_unit #(.ICYC_CLKS(4), .FILE_DEPTH(128)) dut_u (.clk(clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy(busy));
   prog_rom rom_u (.addr(romAddr), .word(romWord));
   // ====
   // Bus tasks
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) nErrors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic check(input string nm, input logic [31:0] e, got);
      samplesChecked++;
      if (got !== e) begin
         nErrors++;
         $display("unexpected %s: expected %h seen %h", nm, e, got);
      end
   endtask
   task automatic rdCheck(input string nm, input logic [7:0] a,
      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(nm, e, rd);
   endtask
   task automatic giveVerdict;
      $display("checks %0d errors %0d", samplesChecked, nErrors);
      if (nErrors == 0 && samplesChecked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ====
   // Reference execution, own arithmetic
   task automatic model(input logic [13:0] w);
      logic [7:0] b, r;
      logic [8:0] s;
      logic [4:0] nb;
      b = w[12] ? mem[w[6:0]] : w[7:0];
      r = acc;
      case (w[13:11])
         3'h0, 3'h2: begin
            s = acc + b;
            nb = {1'b0, acc[3:0]} + {1'b0, b[3:0]};
            flg[`FLG_CARRY] = s[8];
            flg[`FLG_NIBBLE] = nb[4];
            r = s[7:0];
         end
         3'h1, 3'h3: r = acc & b;
         3'h4: r = ~mem[w[6:0]];
         3'h5: mem[w[6:0]][w[9:7]] = 1'b0;
         3'h6: mem[w[6:0]][w[9:7]] = 1'b1;
         default: pc = {latch[4:3], w[10:0]};
      endcase
      if (w[13:11] <= 3'h4) begin
         flg[`FLG_ZERO] = r == 8'h00;
         if ((w[13] | w[12]) & w[7]) mem[w[6:0]] = r;
         else acc = r;
      end
      if (w[13:11] != 3'h7) pc = pc + 13'h1;
   endtask
   // ====
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rdCheck("acc reset", `OFS_ACC, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped err", 32'h1, {31'h0, err});
      apb(1'b1, `OFS_PC, 32'h1234);
      rdCheck("pc read-only", `OFS_PC, 32'h0);
      apb(1'b1, `OFS_ACC, 32'h0F);
      apb(1'b1, `OFS_LATCH, 32'h18);
      apb(1'b1, `OFS_FADDR, 32'h05);
      apb(1'b1, `OFS_FDATA, 32'hF0);
      acc = 8'h0F;
      flg = 3'h0;
      latch = 5'h18;
      pc = 13'h0;
      mem[5] = 8'hF0;
      for (int i = 0; i < 11; i++) begin
         romAddr <= i[3:0];
         @(posedge clk);
         apb(1'b1, `OFS_INSN, {18'h0, romWord});
         model(romWord);
         rdCheck("acc", `OFS_ACC, {24'h0, acc});
         rdCheck("flags", `OFS_FLAGS, {29'h0, flg});
         rdCheck("file", `OFS_FDATA, {24'h0, mem[5]});
         rdCheck("pc", `OFS_PC, {19'h0, pc});
      end
      apb(1'b1, `OFS_FLAGS, 32'h7);
      rdCheck("flags write", `OFS_FLAGS, 32'h7);
      // Stalled read must see faddr, not the instruction's file
      apb(1'b1, `OFS_FADDR, 32'h06);
      apb(1'b1, `OFS_FDATA, 32'h5A);
      apb(1'b1, `OFS_INSN, 32'h2005);
      rdCheck("stalled file", `OFS_FDATA, 32'h5A);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("busy after reset", 32'h0, {31'h0, busy});
      rdCheck("acc after reset", `OFS_ACC, 32'h0);
      rdCheck("flags after reset", `OFS_FLAGS, 32'h0);
      rdCheck("pc after reset", `OFS_PC, 32'h0);
      rdCheck("latch after reset", `OFS_LATCH, 32'h0);
      rdCheck("stat idle", `OFS_STAT, 32'h0);
      giveVerdict;
   end
   // Generous: the sequence needs well under a thousand cycles
   initial begin
      #50000;
      nErrors++;
      giveVerdict;
   end
endmodule
`default_nettype wire

/* tb/exec_chk.sv */
// Bus and execution timing checks for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.vh"
module exec_chk #(
   parameter int ICYC_CLKS = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic busy
);
   // ====
   // Helper state
   logic [4:0] busyCnt;
   logic jumpOp;
   wire access = psel & penable;
   wire insnWr = access & pready & pwrite & (paddr == `OFS_INSN);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busyCnt <= 5'h00;
         jumpOp <= 1'b0;
      end else begin
         busyCnt <= busy ? busyCnt + 5'h01 : 5'h00;
         if (insnWr) begin
            jumpOp <= pwdata[13:11] == `OP_JUMP;
         end
      end
   end
   // ====
   // Properties
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_insnWr;
      insnWr;
   endsequence
   sequence s_busyRun;
      busy [*2];
   endsequence
   property p_start;
      s_insnWr |-> ##[1:2] s_busyRun;
   endproperty
   a_start: assert property (p_start)
      else $error("no execution after write");
   property p_plainLen;
      $fell(busy) && !jumpOp |-> busyCnt == ICYC_CLKS;
   endproperty
   a_plainLen: assert property (p_plainLen)
      else $error("plain op length wrong");
   property p_jumpLen;
      $fell(busy) && jumpOp |-> busyCnt == 2 * ICYC_CLKS;
   endproperty
   a_jumpLen: assert property (p_jumpLen)
      else $error("jump length wrong");
   property p_stall;
      busy |-> !pready;
   endproperty
   a_stall: assert property (p_stall)
      else $error("answer while busy");
   property p_resume;
      $fell(busy) && access |-> ##[0:2] pready;
   endproperty
   a_resume: assert property (p_resume)
      else $error("stalled access not answered");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("pready too long");
   property p_cause;
      pready |-> $past(access);
   endproperty
   a_cause: assert property (p_cause)
      else $error("pready without access");
   property p_idleData;
      !pready |-> prdata == 32'h0 && !pslverr;
   endproperty
   a_idleData: assert property (p_idleData)
      else $error("read data outside answer");
endmodule
bind core_exec_unit exec_chk #(.ICYC_CLKS(ICYC_CLKS)) chk_u (
   .clk(clk),
   .rst_n(rst_n),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .busy(busy)
);
`default_nettype wire

/* tb/prog_rom.sv */
// Program memory model feeding instruction words
`timescale 1ns/1ps
`default_nettype none
module prog_rom (
   input wire logic [3:0] addr,
   output logic [13:0] word
);
   // ====
   // At least one word of each kind, jump near the end to test the wrap
   always_comb begin
      case (addr)
         4'h0: word = 14'h00F1;
         4'h1: word = 14'h003C;
         4'h2: word = 14'h1085;
         4'h3: word = 14'h1805;
         4'h4: word = 14'h2085;
         4'h5: word = 14'h0800;
         4'h6: word = 14'h2805;
         4'h7: word = 14'h3105;
         4'h8: word = 14'h2005;
         4'h9: word = 14'h3FFF;
         default: word = 14'h1005;
      endcase
   end
endmodule
`default_nettype wire
